// ==== verilog/wng_log_pkg.sv ====
// Purpose: Shared constants for the warning and serial error logger.
// Assumes: One clock domain, history depth of ten entries.
// Notes: Codes are eight bits wide.
package wng_log_pkg;
  localparam int HIST_DEPTH = 10;
  localparam int CODE_W = 8;
  localparam int IDX_W = 4;
  localparam int TORQUE_W = 16;
  localparam int ERRCNT_W = 8;
  localparam logic [7:0] CODE_OVERLOAD = 8'h30;
  localparam logic [7:0] CODE_OPERR = 8'h6C;
  localparam logic [7:0] CODE_FRAME = 8'h84;
  localparam logic [7:0] CODE_UNDEF = 8'h88;
  localparam logic [7:0] CODE_TOOLBUSY = 8'h89;
  localparam logic [7:0] CODE_NVBUSY = 8'h8A;
  localparam logic [7:0] CODE_RANGE = 8'h8C;
  localparam logic [7:0] CODE_STATE = 8'h8D;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] ALARM_SERIAL = 8'h84;
  localparam logic [15:0] OVERLOAD_RST = 16'hFFFF;
  localparam logic [7:0] ERRLIMIT_RST = 8'h03;
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_WARN = 3'b010,
    RD_COMM = 3'b100
  } rd_state_t;
endpackage : wng_log_pkg

// ==== verilog/pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Input may change at any time relative to ref_clk.
// Notes: Output changes once stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pins
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] out_nxt;
  assign agree = ~(s2_r ^ s3_r);
  assign out_nxt = (agree & s2_r) | (~agree & out_r);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end
  assign pinOut = out_r;
endmodule : pin_sync

// ==== verilog/code_history.sv ====
// Purpose: Newest-first history of event codes.
// Assumes: At most one push per cycle; clear takes priority over a push.
// Notes: Reset stands for power loss and empties the history.
`timescale 1ns/1ns
module code_history
  import wng_log_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic push,
  input wire logic [CODE_W-1:0] pushCode,
  input wire logic clear,
  // Read port
  input wire logic [IDX_W-1:0] rdIdx,
  output logic [CODE_W-1:0] rdCode,
  output logic [IDX_W-1:0] count
);
  // The count must fit the index width, so fifteen entries at the most.
  if (DEPTH < 1 || DEPTH > 15) begin : g_bad_depth
    $error("code_history: DEPTH out of range");
  end
  logic [CODE_W-1:0] mem_r [DEPTH];
  logic [IDX_W-1:0] count_r;
  logic [IDX_W-1:0] count_nxt;
  assign count_nxt = (count_r == IDX_W'(DEPTH)) ? count_r : count_r + 1'b1;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (clear) begin
      count_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push) begin
      mem_r[0] <= pushCode;
      for (int i = 1; i < DEPTH; i++) begin
        mem_r[i] <= mem_r[i-1];
      end
      count_r <= count_nxt;
    end
  end
  assign count = count_r;
  assign rdCode = (rdIdx < IDX_W'(DEPTH) && rdIdx < count_r) ? mem_r[rdIdx] : CODE_NONE;
endmodule : code_history

// ==== verilog/warning_and_comm_error_logger.sv ====
// Purpose: Warning output and warning/serial error histories of a motor driver.
// Assumes: Frame decoding and command classification are done upstream on ref_clk.
// Notes: Motor control is outside; nothing here gates it.
//
// Overview of operation
// - Warning output rises whenever any warning cause is active.
// - Warnings never stop or inhibit the motor.
// - Warning output falls by itself once all causes are gone.
// - Load torque above overload threshold raises warning 30h.
// - Run input on test exit or active terminal on reassign gives 6Ch.
// - Ten warnings are kept, newest first, in volatile storage.
// - Monitor command returns the warning history.
// - Maintenance command erases the warning history.
// - Power loss empties the warning history.
// - Ten serial error codes are kept, newest first.
// - Monitor command returns the serial error history.
// - Maintenance command erases the serial error history.
// - Power loss empties the serial error history.
// - Framing or block check error is logged as 84h.
// - Undefined command is not executed and logged as 88h.
// - Request during setup-tool session is refused and logged as 89h.
// - Memory busy, internal busy or memory alarm refuses with 8Ah.
// - Out-of-range setting data is rejected and logged as 8Ch.
// - Command not allowed in current state is rejected as 8Dh.
// - Consecutive framing or block check error count reaching the limit raises alarm 84h.
`timescale 1ns/1ns
module warning_and_comm_error_logger
  import wng_log_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Warning causes
  input wire logic [TORQUE_W-1:0] loadTorque,
  input wire logic [TORQUE_W-1:0] overloadLevel,
  input wire logic forward_run_input,
  input wire logic reverse_run_input,
  input wire logic testModeExit,
  input wire logic assignChange,
  input wire logic assignedTermActive,
  // Warning output
  output logic warning_out,
  // Received request, one-cycle valid with its classification
  input wire logic reqValid,
  input wire logic frameErr,
  input wire logic block_check_char_err,
  input wire logic cmdUndefined,
  input wire logic toolSession,
  input wire logic nvProcessing,
  input wire logic internal_busy_flag,
  input wire logic nvAlarm,
  input wire logic dataOutOfRange,
  input wire logic stateForbids,
  input wire logic cmdMonitorWarn,
  input wire logic cmdMonitorComm,
  input wire logic cmdClearWarn,
  input wire logic cmdClearComm,
  input wire logic [ERRCNT_W-1:0] errLimit,
  // Request outcome
  output logic reqExecute,
  output logic reqReject,
  output logic [CODE_W-1:0] rejectCode,
  output logic serialAlarm,
  output logic [CODE_W-1:0] alarmCode,
  // History read-out
  output logic rdValid,
  output logic rdIsComm,
  output logic [IDX_W-1:0] rdIndex,
  output logic [CODE_W-1:0] rdData,
  output logic rdLast
);
  // The histories count in four bits, so fifteen entries at the most.
  if (DEPTH < 1 || DEPTH > 15) begin : g_bad_depth
    $error("logger: DEPTH out of range");
  end

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [1:0] runSync;
  pin_sync #(.WIDTH(2)) u_run_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn({forward_run_input, reverse_run_input}),
    .pinOut(runSync)
  );

  // ****************************************
  // Warning causes
  // ****************************************
  // overload compare
  wire overloadNow = loadTorque > overloadLevel;
  wire opErrEvent = (testModeExit && (runSync != 2'b00)) ||
                    (assignChange && assignedTermActive);
  logic overload_r;
  logic opErr_r;
  logic warn_r;
  // The operation error stays up until the offending inputs drop.
  wire opErr_nxt = opErrEvent || (opErr_r && ((runSync != 2'b00) || assignedTermActive));
  wire overloadRise = overloadNow && !overload_r;
  wire opErrRise = opErr_nxt && !opErr_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      overload_r <= 1'b0;
      opErr_r <= 1'b0;
      warn_r <= 1'b0;
    end else begin
      overload_r <= overloadNow;
      opErr_r <= opErr_nxt;
      warn_r <= overloadNow || opErr_nxt;
    end
  end
  // no motor inhibit: this output reaches no stop path.
  assign warning_out = warn_r;

  // ****************************************
  // Request classification
  // ****************************************
  // Priority follows link order: a broken frame cannot be trusted for anything else.
  function automatic logic [CODE_W-1:0] classify(
    input logic fe, input logic und, input logic tool, input logic nv,
    input logic rng, input logic st);
    if (fe) return CODE_FRAME;
    else if (und) return CODE_UNDEF;
    else if (tool) return CODE_TOOLBUSY;
    else if (nv) return CODE_NVBUSY;
    else if (rng) return CODE_RANGE;
    else if (st) return CODE_STATE;
    else return CODE_NONE;
  endfunction : classify

  logic fe;
  assign fe = frameErr || block_check_char_err;
  logic nvBlock;
  assign nvBlock = nvProcessing || internal_busy_flag || nvAlarm;
  logic [CODE_W-1:0] cls;
  assign cls = classify(fe, cmdUndefined, toolSession, nvBlock, dataOutOfRange, stateForbids);
  logic isReject;
  logic isOk;
  assign isReject = reqValid && (cls != CODE_NONE);
  assign isOk = reqValid && (cls == CODE_NONE);

  // ****************************************
  // Request outcome
  // ****************************************
  logic exec_r;
  logic rej_r;
  logic [CODE_W-1:0] rejCode_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      exec_r <= 1'b0;
      rej_r <= 1'b0;
      rejCode_r <= CODE_NONE;
    end else begin
      exec_r <= isOk;
      rej_r <= isReject;
      if (isReject) begin
        rejCode_r <= cls;
      end
    end
  end
  assign reqExecute = exec_r;
  assign reqReject = rej_r;
  assign rejectCode = rejCode_r;

  // ****************************************
  // Consecutive serial error alarm
  // ****************************************
  logic [ERRCNT_W-1:0] errCnt_r;
  logic [ERRCNT_W-1:0] errCnt_nxt;
  logic alarmHit;
  logic alarm_r;
  logic [CODE_W-1:0] alarmCode_r;
  // The count saturates so that a long burst cannot wrap back under the limit.
  assign errCnt_nxt = (errCnt_r == '1) ? errCnt_r : errCnt_r + 1'b1;
  assign alarmHit = reqValid && fe && (errLimit != '0) && (errCnt_nxt >= errLimit);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      errCnt_r <= '0;
    end else if (reqValid && fe) begin
      errCnt_r <= errCnt_nxt;
    end else if (reqValid) begin
      errCnt_r <= '0;
    end
  end
  // The alarm is sticky: only a reset, which stands for power loss, takes it away.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alarm_r <= 1'b0;
      alarmCode_r <= CODE_NONE;
    end else if (alarmHit) begin
      alarm_r <= 1'b1;
      alarmCode_r <= ALARM_SERIAL;
    end
  end
  assign serialAlarm = alarm_r;
  assign alarmCode = alarmCode_r;

  // ****************************************
  // Histories
  // ****************************************
  logic [IDX_W-1:0] idx_r;
  logic [CODE_W-1:0] warnRd;
  logic [CODE_W-1:0] commRd;
  logic [IDX_W-1:0] warnCount;
  logic [IDX_W-1:0] commCount;
  wire clrWarn = isOk && cmdClearWarn;
  wire clrComm = isOk && cmdClearComm;
  // A new warning wins one entry; if both causes rise together only overload is logged, not 6Ch.
  wire warnPush = overloadRise || opErrRise;
  wire [CODE_W-1:0] warnCode = overloadRise ? CODE_OVERLOAD : CODE_OPERR;

  code_history #(.DEPTH(DEPTH)) u_warn_hist (
    .ref_clk(ref_clk),
    .rst(rst),
    .push(warnPush),
    .pushCode(warnCode),
    .clear(clrWarn),
    .rdIdx(idx_r),
    .rdCode(warnRd),
    .count(warnCount)
  );
  code_history #(.DEPTH(DEPTH)) u_comm_hist (
    .ref_clk(ref_clk),
    .rst(rst),
    .push(isReject),
    .pushCode(cls),
    .clear(clrComm),
    .rdIdx(idx_r),
    .rdCode(commRd),
    .count(commCount)
  );

  // ****************************************
  // Monitor read-out
  // ****************************************
  rd_state_t st_r;
  rd_state_t st_nxt;
  wire lastIdx = idx_r == IDX_W'(DEPTH - 1);
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      RD_IDLE: begin
        if (isOk && cmdMonitorWarn) st_nxt = RD_WARN;
        else if (isOk && cmdMonitorComm) st_nxt = RD_COMM;
      end
      RD_WARN: begin
        if (lastIdx) st_nxt = RD_IDLE;
      end
      RD_COMM: begin
        if (lastIdx) st_nxt = RD_IDLE;
      end
      default: st_nxt = RD_IDLE;
    endcase
  end

  logic rdValid_r;
  logic rdIsComm_r;
  logic [IDX_W-1:0] rdIndex_r;
  logic [CODE_W-1:0] rdData_r;
  logic rdLast_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= RD_IDLE;
      idx_r <= '0;
    end else begin
      st_r <= st_nxt;
      idx_r <= (st_r == RD_IDLE || lastIdx) ? '0 : idx_r + 1'b1;
    end
  end
  // Outputs lag the index by one cycle so that data and index leave together.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdValid_r <= 1'b0;
      rdIsComm_r <= 1'b0;
      rdIndex_r <= '0;
      rdData_r <= CODE_NONE;
      rdLast_r <= 1'b0;
    end else begin
      rdValid_r <= st_r != RD_IDLE;
      rdIsComm_r <= st_r == RD_COMM;
      rdIndex_r <= idx_r;
      rdData_r <= (st_r == RD_COMM) ? commRd : warnRd;
      rdLast_r <= (st_r != RD_IDLE) && lastIdx;
    end
  end
  assign rdValid = rdValid_r;
  assign rdIsComm = rdIsComm_r;
  assign rdIndex = rdIndex_r;
  assign rdData = rdData_r;
  assign rdLast = rdLast_r;
endmodule : warning_and_comm_error_logger

// ==== test/wng_log_checker.sv ====
// Purpose: Port assertions for the warning and serial error logger.
// Assumes: One clock domain, reset active high.
// Notes: Bound to every logger instance.
`timescale 1ns/1ns
module wng_log_checker
  import wng_log_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Inputs
  input wire logic [TORQUE_W-1:0] loadTorque,
  input wire logic [TORQUE_W-1:0] overloadLevel,
  input wire logic reqValid,
  input wire logic frameErr,
  input wire logic block_check_char_err,
  input wire logic cmdUndefined,
  input wire logic toolSession,
  input wire logic nvProcessing,
  input wire logic internal_busy_flag,
  input wire logic nvAlarm,
  input wire logic dataOutOfRange,
  input wire logic stateForbids,
  // Outputs
  input wire logic warning_out,
  input wire logic reqExecute,
  input wire logic reqReject,
  input wire logic [CODE_W-1:0] rejectCode,
  input wire logic serialAlarm,
  input wire logic [CODE_W-1:0] alarmCode,
  input wire logic rdValid,
  input wire logic [IDX_W-1:0] rdIndex,
  input wire logic rdLast
);
  // ****************
  // Request priority
  // ****************
  // Each stage has passed every higher refusal cause.
  wire ok1 = reqValid & ~frameErr & ~block_check_char_err;
  wire ok2 = ok1 & ~cmdUndefined;
  wire ok3 = ok2 & ~toolSession;
  wire ok4 = ok3 & ~(nvProcessing | internal_busy_flag | nvAlarm);
  wire ok5 = ok4 & ~dataOutOfRange;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence dump_s;
    rdValid ##1 rdValid [*8] ##1 (rdValid && rdLast);
  endsequence
  a_ovl_warn: assert property (loadTorque > overloadLevel |=> warning_out)
    else $error("overload gave no warning");
  a_frame_code: assert property (reqValid && !ok1 |=> reqReject && rejectCode == CODE_FRAME)
    else $error("frame error code wrong");
  a_undef_code: assert property (ok1 && cmdUndefined |=> !reqExecute && rejectCode == CODE_UNDEF)
    else $error("undefined command code wrong");
  a_tool_code: assert property (ok2 && toolSession |=> rejectCode == CODE_TOOLBUSY)
    else $error("tool busy code wrong");
  a_nv_code: assert property (ok3 && !ok4 |=> reqReject && rejectCode == CODE_NVBUSY)
    else $error("memory busy code wrong");
  a_range_code: assert property (ok4 && dataOutOfRange |=> rejectCode == CODE_RANGE)
    else $error("range code wrong");
  a_state_code: assert property (ok5 && stateForbids |=> rejectCode == CODE_STATE)
    else $error("state code wrong");
  a_clean_exec: assert property (ok5 && !stateForbids |=> reqExecute && !reqReject)
    else $error("clean request not executed");
  a_dump_len: assert property (rdValid && rdIndex == 4'h0 |-> dump_s)
    else $error("read-out length wrong");
  a_alarm_cause: assert property ($rose(serialAlarm) |-> $past(reqValid && !ok1))
    else $error("alarm without frame error");
  a_alarm_code: assert property (serialAlarm |=> serialAlarm && alarmCode == ALARM_SERIAL)
    else $error("alarm dropped or code wrong");
endmodule : wng_log_checker
bind warning_and_comm_error_logger wng_log_checker wng_log_checker_inst (.*);

// ==== test/master_model.sv ====
// Purpose: Serial master handing classified requests to the logger.
// Assumes: Called at a falling edge of ref_clk.
// Notes: Flags are frame, check, undefined, tool, nv, busy, nv alarm,
//   range, state, monitor warn, monitor comm, clear warn, clear comm.
`timescale 1ns/1ns
module master_model (
  // Clock
  input wire logic ref_clk,
  // Request
  output logic reqValid,
  output logic [12:0] reqFlags
);
  initial begin
    reqValid = 1'h0;
    reqFlags = 13'h0000;
  end
  // requests of every kind, and idle
  // Valid stays up so that requests can run back to back.
  task automatic send(input logic [12:0] f);
    reqValid = 1'h1;
    reqFlags = f;
    @(negedge ref_clk);
  endtask : send
  // Released flags carry junk, never the last value.
  task automatic idle(input int n);
    reqValid = 1'h0;
    reqFlags = ~reqFlags;
    repeat (n) @(negedge ref_clk);
  endtask : idle
endmodule : master_model

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the warning and serial error logger.
// Assumes: Inputs change at the falling edge.
// Notes: Error limit is three, and zero once to show the alarm disabled.
`timescale 1ns/1ns
module tb
  import wng_log_pkg::*;
;
  `define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
  localparam logic [12:0] F_FE = 13'h1000, F_BC = 13'h0800, F_UN = 13'h0400;
  localparam logic [12:0] F_TL = 13'h0200, F_NV = 13'h0100, F_BY = 13'h0080;
  localparam logic [12:0] F_NA = 13'h0040, F_RG = 13'h0020, F_ST = 13'h0010;
  localparam logic [12:0] F_MW = 13'h0008, F_MC = 13'h0004, F_CW = 13'h0002;
  localparam logic [12:0] F_CC = 13'h0001;
  logic ref_clk, rst, forward_run_input, reverse_run_input, testModeExit, assignChange;
  logic assignedTermActive, warning_out, reqValid, frameErr, block_check_char_err;
  logic cmdUndefined, toolSession, nvProcessing, internal_busy_flag, nvAlarm;
  logic dataOutOfRange, stateForbids, cmdMonitorWarn, cmdMonitorComm, cmdClearWarn;
  logic cmdClearComm, reqExecute, reqReject, serialAlarm, rdValid, rdIsComm, rdLast;
  logic [TORQUE_W-1:0] loadTorque, overloadLevel;
  logic [ERRCNT_W-1:0] errLimit;
  logic [CODE_W-1:0] rejectCode, alarmCode, rdData;
  logic [IDX_W-1:0] rdIndex;
  logic [12:0] reqFlags;
  int errors, checks;
  assign {frameErr, block_check_char_err, cmdUndefined, toolSession, nvProcessing,
    internal_busy_flag, nvAlarm, dataOutOfRange, stateForbids, cmdMonitorWarn,
    cmdMonitorComm, cmdClearWarn, cmdClearComm} = reqFlags;
  master_model master_model_inst (.ref_clk(ref_clk), .reqValid(reqValid), .reqFlags(reqFlags));
  warning_and_comm_error_logger warning_and_comm_error_logger_inst (.*);
  always #2 ref_clk = ~ref_clk;
  // ********
  // Scenarios
  // ********
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  task automatic dump(input logic [12:0] f, input logic [79:0] e);
    int n;
    master_model_inst.send(f);
    master_model_inst.idle(0);
    n = 0;
    while (rdValid !== 1'h1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    for (int i = 0; i < 10; i++) begin
      `CHK(rdData, e[79-8*i -: 8])
      `CHK({rdIsComm, rdIndex, rdLast}, {f[2], i[3:0], i == 9})
      @(negedge ref_clk);
    end
  endtask : dump
  task automatic t_warn;
    loadTorque = 16'h1000;
    @(negedge ref_clk);
    `CHK(warning_out, 1'h0)
    loadTorque = 16'h1001;
    @(negedge ref_clk);
    `CHK(warning_out, 1'h1)
    loadTorque = 16'h0FFF;
    @(negedge ref_clk);
    `CHK(warning_out, 1'h0)
    forward_run_input = 1'h1;
    repeat (6) @(negedge ref_clk);
    testModeExit = 1'h1;
    @(negedge ref_clk);
    testModeExit = 1'h0;
    @(negedge ref_clk);
    `CHK(warning_out, 1'h1)
    forward_run_input = 1'h0;
    repeat (8) @(negedge ref_clk);
    `CHK(warning_out, 1'h0)
    assignedTermActive = 1'h1;
    assignChange = 1'h1;
    @(negedge ref_clk);
    assignChange = 1'h0;
    @(negedge ref_clk);
    `CHK(warning_out, 1'h1)
    assignedTermActive = 1'h0;
    repeat (2) @(negedge ref_clk);
    reverse_run_input = 1'h1;
    repeat (6) @(negedge ref_clk);
    testModeExit = 1'h1;
    @(negedge ref_clk);
    testModeExit = 1'h0;
    reverse_run_input = 1'h0;
    @(negedge ref_clk);
    `CHK(warning_out, 1'h1)
    repeat (8) @(negedge ref_clk);
    `CHK(warning_out, 1'h0)
    dump(F_MW, {8'h6C, 8'h6C, 8'h6C, 8'h30, 48'h0});
    $display("test warnings done");
  endtask : t_warn
  task automatic t_codes;
    logic [12:0] fl [9];
    logic [7:0] cd [9];
    fl = '{F_FE, F_BC, F_UN | F_TL, F_TL | F_NV, F_NV, F_BY, F_NA | F_RG, F_RG | F_ST,
      F_ST | F_CC};
    cd = '{8'h84, 8'h84, 8'h88, 8'h89, 8'h8A, 8'h8A, 8'h8A, 8'h8C, 8'h8D};
    for (int i = 0; i < 9; i++) begin
      master_model_inst.send(fl[i]);
      `CHK({reqReject, reqExecute, rejectCode}, {2'h2, cd[i]})
    end
    master_model_inst.send(F_FE);
    master_model_inst.send(F_FE);
    `CHK(serialAlarm, 1'h0)
    master_model_inst.send(F_FE);
    master_model_inst.idle(1);
    `CHK({serialAlarm, alarmCode}, {1'h1, 8'h84})
    dump(F_MC, 80'h8484848D8C8A8A8A8988);
    $display("test codes done");
  endtask : t_codes
  task automatic t_clear;
    master_model_inst.send(F_CW);
    `CHK({reqReject, reqExecute}, 2'h1)
    master_model_inst.send(F_CC);
    `CHK({reqReject, reqExecute}, 2'h1)
    master_model_inst.idle(1);
    dump(F_MW, 80'h0);
    dump(F_MC, 80'h0);
    master_model_inst.send(F_UN);
    master_model_inst.idle(0);
    overloadLevel = 16'h0010;
    loadTorque = 16'h0011;
    repeat (3) @(negedge ref_clk);
    `CHK(warning_out, 1'h1)
    rst = 1'h1;
    loadTorque = 16'h0000;
    repeat (2) @(negedge ref_clk);
    `CHK({warning_out, serialAlarm, reqReject}, 3'h0)
    rst = 1'h0;
    @(negedge ref_clk);
    dump(F_MC, 80'h0);
    dump(F_MW, 80'h0);
    errLimit = 8'h00;
    repeat (4) master_model_inst.send(F_FE);
    master_model_inst.idle(1);
    `CHK(serialAlarm, 1'h0)
    $display("test clear done");
  endtask : t_clear
  initial begin
    #20000;
    errors++;
    $display("unexpected at %0t: watchdog", $time);
    give_verdict();
  end
  initial begin
    {ref_clk, rst, forward_run_input, reverse_run_input} = 4'h4;
    {testModeExit, assignChange, assignedTermActive} = 3'h0;
    loadTorque = 16'h0000;
    overloadLevel = 16'h1000;
    errLimit = 8'h03;
    errors = 0;
    checks = 0;
    repeat (4) @(negedge ref_clk);
    rst = 1'h0;
    @(negedge ref_clk);
    t_warn();
    t_codes();
    t_clear();
    give_verdict();
  end
endmodule : tb
